// [core/pp_port.v]
`timescale 1ns/1ps
`include "pp_regs.vh"

// What this block does
// - Eight ports; offsets 3-7 only in enhanced
// - Reset clears the data latch
// - Data write latched, driven uninverted to pins
// - Standard data read returns live pins
// - Status held stable through each read
// - Status bit 0 is enhanced time-out flag
// - Select 0: status read end clears flag
// - Select 1: writing one clears flag
// - Hard reset clears time-out flag
// - Status bits 1,2 read zero
// - Status 3-6 mirror error/online/paper/ack pins
// - Status bit 7 is inverted busy
// - Status write in enhanced only clears flag
// - Reset control 0-5; bits 6,7 zero
// - Control 0 inverted onto strobe pin
// - Control 1 inverted onto line-feed pin
// - Control 2 uninverted onto init pin
// - Control 3 inverted onto select pin
// - Ack rising edge interrupts when enabled
// - Control 5 sets direction; printer always out
// - Ten microsecond wait aborts, sets flag
module pp_port (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Host I/O port
  input wire [2:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_rd,
  input wire io_wr,
  output reg [7:0] io_rdata,
  output reg io_ready,
  // Configuration
  input wire [1:0] port_mode,
  input wire timeout_select,
  // Data pins
  input wire [7:0] par_data_pin_i,
  output reg [7:0] par_data_pin_o,
  output reg par_data_pin_oe_n,
  // Control pins
  output reg data_strobe_pin_n,
  output reg line_feed_pin_n,
  output reg printer_init_pin,
  output reg printer_select_pin_n,
  // Status pins
  input wire printer_error_in,
  input wire printer_online_in,
  input wire paper_out_in,
  input wire printer_ack_in,
  input wire printer_busy_in,
  // Interrupt
  output reg ack_irq
);

  // ************************************************************
  // Cycle states
  // ************************************************************
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_WAITLO = 4'h2;
  localparam [3:0] ST_STROBE = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  wire [12:0] pins_s;
  wire [7:0] data_s;
  wire err_s;
  wire online_s;
  wire paper_s;
  wire ack_s;
  wire busy_s;

  pp_sync #(.WIDTH(13)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async_in({printer_busy_in, printer_ack_in, paper_out_in, printer_online_in, printer_error_in,
               par_data_pin_i}),
    .sync_out(pins_s)
  );

  assign data_s = pins_s[7:0];
  assign err_s = pins_s[8];
  assign online_s = pins_s[9];
  assign paper_s = pins_s[10];
  assign ack_s = pins_s[11];
  assign busy_s = pins_s[12];

  // ************************************************************
  // State
  // ************************************************************
  reg [3:0] state;
  reg [3:0] next_state;
  reg [7:0] data_latch;
  reg [`PP_CT_WIDTH-1:0] ctrl;
  reg [7:0] epp_addr;
  reg [7:0] epp_data;
  reg tmo_flag;
  reg [2:0] cur_addr;
  reg cur_wr;
  reg epp_drive;
  reg ack_d;
  wire expired;

  // Decodes for the request presented this cycle
  wire is_epp = (port_mode == `PP_MODE_EPP);
  wire req = io_rd | io_wr;
  wire take = (state == ST_IDLE) && req;
  wire epp_ofs = (io_addr >= `PP_OFS_EADDR);
  wire epp_take = take && is_epp && epp_ofs;
  wire cur_is_addr = (cur_addr == `PP_OFS_EADDR);
  wire in_cycle = (state == ST_WAITLO) || (state == ST_STROBE);

  // With direction set to input an enhanced write only looks like a read
  wire wr_drive = io_wr && !ctrl[`PP_CT_DIR];

  // Live status image, bits 1 and 2 have no storage
  wire [7:0] status_img = {~busy_s, ack_s, paper_s, online_s, err_s, 2'b00, tmo_flag & is_epp};

  // ************************************************************
  // Watchdog
  // ************************************************************
  pp_timer u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .clr(epp_take),
    .run(in_cycle),
    .expired(expired)
  );

  // Abort when the peripheral holds wait too long
  wire abort = in_cycle && expired;
  wire strobe_end = (state == ST_STROBE) && busy_s && !expired;

  // ************************************************************
  // Sequencer
  // ************************************************************
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (epp_take) begin
          next_state = ST_WAITLO;
        end else if (take) begin
          next_state = ST_DONE;
        end
      end
      ST_WAITLO: begin
        if (abort) begin
          next_state = ST_DONE;
        end else if (!busy_s) begin
          next_state = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (abort || strobe_end) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!req) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Time-out flag
  // ************************************************************
  // Set wins over any clear landing in the same cycle
  wire tmo_clr_rd = (state == ST_DONE) && !req && !cur_wr && (cur_addr == `PP_OFS_STATUS)
                    && !timeout_select;
  wire tmo_clr_wr = take && io_wr && is_epp && (io_addr == `PP_OFS_STATUS)
                    && timeout_select && io_wdata[`PP_ST_TMO];
  wire next_tmo = abort | (tmo_flag & ~(tmo_clr_rd | tmo_clr_wr));

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tmo_flag <= 1'b0;
    end else begin
      tmo_flag <= next_tmo;
    end
  end

  // ************************************************************
  // Registers written by the host
  // ************************************************************
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      data_latch <= `PP_DATA_RST;
      ctrl <= `PP_CTRL_RST;
      epp_addr <= `PP_EPP_RST;
      epp_data <= `PP_EPP_RST;
      cur_addr <= `PP_OFS_DATA;
      cur_wr <= 1'b0;
    end else if (take) begin
      cur_addr <= io_addr;
      cur_wr <= io_wr;
      if (io_wr) begin
        case (io_addr)
          `PP_OFS_DATA: begin
            data_latch <= io_wdata;
          end
          `PP_OFS_CONTROL: begin
            ctrl <= io_wdata[`PP_CT_WIDTH-1:0];
          end
          `PP_OFS_EADDR: begin
            if (is_epp) begin
              epp_addr <= io_wdata;
            end
          end
          default: begin
            if (is_epp && epp_ofs) begin
              epp_data <= io_wdata;
            end
          end
        endcase
      end
    end
  end

  // Drive enable for an enhanced write; the byte comes from the stored port
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      epp_drive <= 1'b0;
    end else if (epp_take) begin
      epp_drive <= wr_drive;
    end else if (state == ST_DONE) begin
      epp_drive <= 1'b0;
    end
  end

  // ************************************************************
  // Read data and ready
  // ************************************************************
  // Status is captured once at the take and held until the host lets go
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata <= `PP_RDATA_RST;
      io_ready <= 1'b0;
    end else begin
      io_ready <= 1'b0;
      if (take && !epp_take) begin
        io_ready <= 1'b1;
        case (io_addr)
          `PP_OFS_DATA: io_rdata <= data_s;
          `PP_OFS_STATUS: io_rdata <= status_img;
          `PP_OFS_CONTROL: io_rdata <= {2'b00, ctrl};
          default: io_rdata <= `PP_UNMAPPED_RD;
        endcase
      end else if (strobe_end || abort) begin
        io_ready <= 1'b1;
        if (!cur_wr || !epp_drive) begin
          io_rdata <= data_s;
        end
      end else if ((state == ST_DONE) && io_rd && (cur_addr == `PP_OFS_DATA)) begin
        io_rdata <= data_s;
      end
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  reg [7:0] next_pd;
  reg next_oe_n;
  reg next_strobe_n;
  reg next_lf_n;
  reg next_sel_n;

  // Enhanced cycles borrow strobe, line-feed and select pins
  always @* begin
    next_pd = data_latch;
    next_oe_n = 1'b0;
    if (port_mode != `PP_MODE_PRINTER) begin
      next_oe_n = ctrl[`PP_CT_DIR];
    end
    next_strobe_n = ~ctrl[`PP_CT_STROBE];
    next_lf_n = ~ctrl[`PP_CT_LF];
    next_sel_n = ~ctrl[`PP_CT_SELECT];
    if (in_cycle && !abort) begin
      if (epp_drive) begin
        next_pd = cur_is_addr ? epp_addr : epp_data;
        next_oe_n = 1'b0;
      end else begin
        next_oe_n = 1'b1;
      end
      next_strobe_n = ~epp_drive;
      if ((state == ST_STROBE) && !strobe_end) begin
        next_lf_n = cur_is_addr;
        next_sel_n = ~cur_is_addr;
      end else if ((state == ST_WAITLO) && !busy_s) begin
        next_lf_n = cur_is_addr;
        next_sel_n = ~cur_is_addr;
      end else begin
        next_lf_n = 1'b1;
        next_sel_n = 1'b1;
      end
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      par_data_pin_o <= `PP_DATA_RST;
      par_data_pin_oe_n <= 1'b0;
      data_strobe_pin_n <= 1'b1;
      line_feed_pin_n <= 1'b1;
      printer_init_pin <= 1'b0;
      printer_select_pin_n <= 1'b1;
    end else begin
      par_data_pin_o <= next_pd;
      par_data_pin_oe_n <= next_oe_n;
      data_strobe_pin_n <= next_strobe_n;
      line_feed_pin_n <= next_lf_n;
      printer_init_pin <= ctrl[`PP_CT_INIT];
      printer_select_pin_n <= next_sel_n;
    end
  end

  // ************************************************************
  // Acknowledge interrupt
  // ************************************************************
  // One-cycle pulse per rising ack edge, gated by the enable bit
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_d <= 1'b0;
      ack_irq <= 1'b0;
    end else begin
      ack_d <= ack_s;
      ack_irq <= ctrl[`PP_CT_ACK_IRQ_ENABLE] && ack_s && !ack_d;
    end
  end

endmodule // pp_port

// [core/pp_regs.vh]
`ifndef PP_REGS_VH
`define PP_REGS_VH

// ************************************************************
// Port offsets
// ************************************************************
`define PP_OFS_DATA 3'h0
`define PP_OFS_STATUS 3'h1
`define PP_OFS_CONTROL 3'h2
`define PP_OFS_EADDR 3'h3
`define PP_OFS_EDATA_A 3'h4
`define PP_OFS_EDATA_B 3'h5
`define PP_OFS_EDATA_C 3'h6
`define PP_OFS_EDATA_D 3'h7

// ************************************************************
// Status fields
// ************************************************************
`define PP_ST_TMO 0
`define PP_ST_ERR 3
`define PP_ST_ONLINE 4
`define PP_ST_PAPER 5
`define PP_ST_ACK 6
`define PP_ST_READY 7

// ************************************************************
// Control fields
// ************************************************************
`define PP_CT_STROBE 0
`define PP_CT_LF 1
`define PP_CT_INIT 2
`define PP_CT_SELECT 3
`define PP_CT_ACK_IRQ_ENABLE 4
`define PP_CT_DIR 5
`define PP_CT_WIDTH 6

// ************************************************************
// Reset values and modes
// ************************************************************
`define PP_DATA_RST 8'h00
`define PP_CTRL_RST 6'h00
`define PP_EPP_RST 8'h00
`define PP_UNMAPPED_RD 8'h00
`define PP_RDATA_RST 8'h00
`define PP_MODE_PRINTER 2'h0
`define PP_MODE_BIDIR 2'h1
`define PP_MODE_EPP 2'h2

// ************************************************************
// Timing
// ************************************************************
`define PP_CLK_NS 50
`define PP_TMO_NS 10000
`define PP_TMO_CYCLES (`PP_TMO_NS / `PP_CLK_NS)
`define PP_TMO_CW 8

`endif

// [core/pp_sync.v]
`timescale 1ns/1ps

// ************************************************************
// Two-stage synchroniser for pin inputs
// ************************************************************
module pp_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Asynchronous in, synchronised out
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // First stage feeds only the second; nothing else looks at it
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // pp_sync

// [core/pp_timer.v]
`timescale 1ns/1ps
`include "pp_regs.vh"

// ************************************************************
// Enhanced-cycle watchdog
// ************************************************************
module pp_timer (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Control
  input wire clr,
  input wire run,
  // Result
  output reg expired
);

  // Worked out at full width, then cut to the counter on purpose
  localparam integer LAST_I = `PP_TMO_CYCLES - 1;
  localparam [`PP_TMO_CW-1:0] LAST = LAST_I[`PP_TMO_CW-1:0];

  reg [`PP_TMO_CW-1:0] count;

  // Counts run cycles since the last clear; sticks once expired
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count <= {`PP_TMO_CW{1'b0}};
      expired <= 1'b0;
    end else if (clr) begin
      count <= {`PP_TMO_CW{1'b0}};
      expired <= 1'b0;
    end else if (run && !expired) begin
      if (count == LAST) begin
        expired <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule // pp_timer

// [sim/pp_port_props.sv]
`timescale 1ns/1ps
// ****
// Port checker
// ****
module pp_port_props (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Host side
  input wire [2:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_rd,
  input wire io_wr,
  input wire [7:0] io_rdata,
  input wire io_ready,
  input wire [1:0] port_mode,
  // Pins
  input wire [7:0] par_data_pin_o,
  input wire par_data_pin_oe_n,
  input wire data_strobe_pin_n,
  input wire line_feed_pin_n,
  input wire printer_init_pin,
  input wire printer_select_pin_n,
  input wire ack_irq
);
  reg [7:0] wd_hold;
  reg [8:0] wait_cnt;
  wire wr_done = io_ready && io_wr;
  wire st_rd = io_ready && io_rd && io_addr == 3'h1;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Keep the byte, since the host may drop it right after ready
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) wd_hold <= 8'h00;
    else if (wr_done) wd_hold <= io_wdata;
  end
  // Open request age; a lost handshake grows it
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) wait_cnt <= 9'h000;
    else if (io_ready || !(io_rd || io_wr)) wait_cnt <= 9'h000;
    else wait_cnt <= wait_cnt + 9'h001;
  end
  chk_ctl_strobe_lf: assert property (wr_done && io_addr == 3'h2 |-> ##2
    data_strobe_pin_n == !wd_hold[0] && line_feed_pin_n == !wd_hold[1]) else $error("strobe or feed pin wrong");
  chk_ctl_init_sel: assert property (wr_done && io_addr == 3'h2 |-> ##2
    printer_init_pin == wd_hold[2] && printer_select_pin_n == !wd_hold[3]) else $error("init or select pin wrong");
  chk_data_drive: assert property (wr_done && io_addr == 3'h0 |-> ##2 par_data_pin_o == wd_hold)
    else $error("data pins differ from write");
  chk_status_zero: assert property (st_rd |-> io_rdata[2:1] == 2'h0) else $error("status bits 1-2 set");
  chk_unmapped_zero: assert property (io_ready && io_rd && io_addr > 3'h2 && port_mode != 2'h2
    |-> io_rdata == 8'h00) else $error("unmapped read not zero");
  chk_printer_out: assert property (port_mode == 2'h0 && $past(port_mode) == 2'h0
    |-> !par_data_pin_oe_n) else $error("printer mode not driving");
  chk_irq_pulse: assert property (ack_irq |=> !ack_irq) else $error("irq longer than a cycle");
  chk_cycle_abort: assert property (wait_cnt < 9'h0d2) else $error("request never answered");
  chk_reset_pins: assert property ($rose(rst_b) |-> data_strobe_pin_n && line_feed_pin_n
    && printer_select_pin_n && !printer_init_pin && par_data_pin_o == 8'h00) else $error("bad reset pins");
  cov_epp_wr: cover property (wr_done && io_addr > 3'h2);
  cov_st_rd: cover property (st_rd);
  cov_irq: cover property (ack_irq);
endmodule // pp_port_props

bind pp_port pp_port_props i_pp_port_props (.mclk(mclk), .rst_b(rst_b), .io_addr(io_addr),
  .io_wdata(io_wdata), .io_rd(io_rd), .io_wr(io_wr), .io_rdata(io_rdata), .io_ready(io_ready),
  .port_mode(port_mode), .par_data_pin_o(par_data_pin_o), .par_data_pin_oe_n(par_data_pin_oe_n),
  .data_strobe_pin_n(data_strobe_pin_n), .line_feed_pin_n(line_feed_pin_n),
  .printer_init_pin(printer_init_pin), .printer_select_pin_n(printer_select_pin_n), .ack_irq(ack_irq));

// [sim/pp_periph.sv]
`timescale 1ns/1ps
// ****
// Peripheral model
// ****
module pp_periph (
  // Clock
  input wire mclk,
  // Bench control
  input wire epp,
  input wire hang,
  input wire busy_lvl,
  input wire [3:0] dly,
  input wire [7:0] drv_byte,
  output reg [7:0] got,
  // Cable
  input wire [7:0] pd_o,
  input wire pd_oe_n,
  input wire dstb_n,
  input wire astb_n,
  output wire [7:0] pd_i,
  output wire busy
);
  reg [3:0] cnt = 4'h0;
  reg wt_n = 1'b0;
  wire stb = epp && !(dstb_n && astb_n);
  // Wire level: the device when its enable is low, else us
  assign pd_i = pd_oe_n ? drv_byte : pd_o;
  assign busy = epp ? wt_n : busy_lvl;
  // Release wait after dly cycles of strobe; hang never does
  always @(posedge mclk) begin
    // Saturate, so a long strobe never wraps and drops wait again
    cnt <= !stb ? 4'h0 : (cnt == 4'hf) ? cnt : cnt + 4'h1;
    wt_n <= stb && !hang && cnt >= dly;
  end
  // Take the byte at strobe end, as a real peripheral would
  always @(posedge dstb_n or posedge astb_n) begin
    if (epp && !pd_oe_n) got <= pd_o;
  end
endmodule // pp_periph

// [sim/tb_top.sv]
`timescale 1ns/1ps
// ****
// Bench top
// ****
module tb_top;
  reg mclk = 1'b0;
  reg rst_b = 1'b0;
  reg [2:0] io_addr = 3'h0;
  reg [7:0] io_wdata = 8'h00;
  reg io_rd = 1'b0;
  reg io_wr = 1'b0;
  reg [1:0] port_mode = 2'h0;
  reg timeout_select = 1'b0;
  reg [3:0] st = 4'h0;
  reg busy_lvl = 1'b0;
  reg epp = 1'b0;
  reg hang = 1'b0;
  reg [3:0] dly = 4'h0;
  reg [7:0] drv = 8'h00;
  reg [15:0] rnd = 16'h5d74;
  reg [7:0] irqs = 8'h00;
  reg [7:0] rd;
  reg [7:0] b;
  wire [7:0] io_rdata, pd_o, pd_i, got;
  wire io_ready, oe_n, stb_n, lf_n, init, sel_n, busy, ack_irq;
  integer miscompares = 0;
  integer checked = 0;
  integer i;
  always #25 mclk = ~mclk;
  // Count interrupt pulses
  always @(posedge mclk) if (ack_irq === 1'b1) irqs <= irqs + 8'h01;
  pp_port i_pp_port (.mclk(mclk), .rst_b(rst_b), .io_addr(io_addr), .io_wdata(io_wdata), .io_rd(io_rd),
    .io_wr(io_wr), .io_rdata(io_rdata), .io_ready(io_ready), .port_mode(port_mode),
    .timeout_select(timeout_select), .par_data_pin_i(pd_i), .par_data_pin_o(pd_o), .par_data_pin_oe_n(oe_n),
    .data_strobe_pin_n(stb_n), .line_feed_pin_n(lf_n), .printer_init_pin(init), .printer_select_pin_n(sel_n),
    .printer_error_in(st[0]), .printer_online_in(st[1]), .paper_out_in(st[2]), .printer_ack_in(st[3]),
    .printer_busy_in(busy), .ack_irq(ack_irq));
  pp_periph i_pp_periph (.mclk(mclk), .epp(epp), .hang(hang), .busy_lvl(busy_lvl), .dly(dly),
    .drv_byte(drv), .got(got), .pd_o(pd_o), .pd_oe_n(oe_n), .dstb_n(lf_n), .astb_n(sel_n),
    .pd_i(pd_i), .busy(busy));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Status byte: busy inverted on top, pins straight, low bits clear
  function [7:0] st_exp(input [3:0] p, input bz);
    st_exp = {~bz, p, 3'h0};
  endfunction
  task check(input string name, input [7:0] seen, input [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value %0s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One host access; the request holds until ready is seen at an edge
  task io(input w, input [2:0] a, input [7:0] d);
    integer n;
    @(negedge mclk);
    io_addr = a;
    io_wdata = d;
    io_rd = !w;
    io_wr = w;
    n = 0;
    do begin
      @(posedge mclk);
      n = n + 1;
    end while (io_ready !== 1'b1 && n < 400);
    if (n >= 400) miscompares = miscompares + 1;
    rd = io_rdata;
    @(negedge mclk);
    io_rd = 1'b0;
    io_wr = 1'b0;
    @(negedge mclk);
  endtask
  task finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    io(0, 3'h0, 8'h00);
    check("data", rd, 8'h00);
    io(0, 3'h2, 8'h00);
    check("ctl", rd, 8'h00);
    check("pins", {stb_n, lf_n, init, sel_n}, 8'h0d);
    for (i = 0; i < 8; i = i + 1) begin
      rnd = lfsr(rnd);
      b = (i == 0) ? 8'hff : rnd[7:0];
      io(1, 3'h0, b);
      io(0, 3'h0, 8'h00);
      check("data", rd, b);
      check("pd_o", pd_o, b);
      io(1, 3'h2, b);
      io(0, 3'h2, 8'h00);
      check("ctl", rd, {2'h0, b[5:0]});
      check("pins", {stb_n, lf_n, init, sel_n}, {4'h0, ~b[0], ~b[1], b[2], ~b[3]});
      {busy_lvl, st} = rnd[12:8];
      repeat (4) @(negedge mclk);
      io(0, 3'h1, 8'h00);
      check("status", rd, st_exp(st, busy_lvl));
    end
    port_mode = 2'h1;
    drv = rnd[15:8];
    io(1, 3'h2, 8'h20);
    repeat (3) @(negedge mclk);
    io(0, 3'h0, 8'h00);
    check("bidir", rd, drv);
    check("oe_n", oe_n, 8'h01);
    port_mode = 2'h0;
    repeat (2) @(negedge mclk);
    check("oe_n", oe_n, 8'h00);
    for (i = 3; i < 8; i = i + 1) begin
      io(1, i[2:0], 8'h5a);
      io(0, i[2:0], 8'h00);
      check("unmapped", rd, 8'h00);
    end
    port_mode = 2'h2;
    epp = 1'b1;
    io(1, 3'h2, 8'h04);
    for (i = 3; i < 8; i = i + 1) begin
      rnd = lfsr(rnd);
      dly = rnd[3:0];
      drv = rnd[15:8];
      io(1, i[2:0], rnd[7:0]);
      check("epp_wr", got, rnd[7:0]);
      io(0, i[2:0], 8'h00);
      check("epp_rd", rd, drv);
    end
    hang = 1'b1;
    io(1, 3'h4, 8'h11);
    io(0, 3'h1, 8'h00);
    check("tmo", rd[0], 8'h01);
    io(0, 3'h1, 8'h00);
    check("tmo", rd[0], 8'h00);
    timeout_select = 1'b1;
    io(1, 3'h4, 8'h11);
    io(0, 3'h1, 8'h00);
    io(1, 3'h1, 8'h00);
    io(0, 3'h1, 8'h00);
    check("tmo", rd[0], 8'h01);
    io(1, 3'h1, 8'h01);
    io(0, 3'h1, 8'h00);
    check("tmo", rd[0], 8'h00);
    io(1, 3'h4, 8'h11);
    rst_b = 1'b0;
    @(negedge mclk);
    rst_b = 1'b1;
    io(0, 3'h1, 8'h00);
    check("tmo", rd[0], 8'h00);
    hang = 1'b0;
    epp = 1'b0;
    port_mode = 2'h0;
    for (i = 0; i < 2; i = i + 1) begin
      io(1, 3'h2, {3'h0, ~i[0], 4'h0});
      st[3] = 1'b0;
      repeat (4) @(negedge mclk);
      b = irqs;
      st[3] = 1'b1;
      repeat (6) @(negedge mclk);
      check("irq", irqs - b, {7'h00, ~i[0]});
    end
    finish_test;
  end
  // Watchdog, far beyond the expected run
  initial begin
    #2000000;
    miscompares = miscompares + 1;
    finish_test;
  end
endmodule // tb_top
